// file: core/los_defs.vh
/*
 * constants for the local operand store: widths, field positions and
 * operand-class codes.
 * assumes bit 0 of the architecture is the msb of each word.
 */
// Behaviour
// [RQ1] immediate operand is instruction bits 8-15
// [RQ2] sixteen general registers, four-bit select
// [RQ3] odd or high floating select raises specification fault
// [RQ4] op code alone picks general or floating set
// [RQ5] general registers are 32 bits, word default
// [RQ6] doubleword uses even register high, next low
// [RQ7] floating registers 64 bits, short or long
// [RQ8] short floating operand uses upper word only
// [RQ9] sign sits in bit position 0
// [RQ10] signed two's complement fixed-point values
// [RQ11] widening copies sign into added bits
// [RQ12] 64-bit dividends and products in register pair
// [RQ13] odd register top bit is ordinary data
// [RQ14] storage operands aligned to their length; los_store does not check alignment
// [RQ15] fetched halfword sign-extended into full word
// [RQ16] floating: sign, 7-bit characteristic, hex fraction
// [RQ17] decimal digits four-bit, two per byte
// [RQ18] zero base or index field reads zero
// [RQ19] writes on clock edge, reads see old value
`ifndef LOS_DEFS_VH
`define LOS_DEFS_VH
`define LOS_WORD_W      32
`define LOS_DWORD_W     64
`define LOS_HALF_W      16
`define LOS_SEL_W       4
`define LOS_GEN_COUNT   16
`define LOS_FLT_COUNT   4
`define LOS_OP_W        8
`define LOS_INSN_W      16
`define LOS_IMM_HI      7
`define LOS_IMM_LO      0
`define LOS_CHAR_W      7
`define LOS_FRAC_SHORT  24
`define LOS_FRAC_LONG   56
`define LOS_DIGIT_W     4
// op-code class field: op bits 2 and 3 (architectural numbering)
`define LOS_CLASS_HI    5
`define LOS_CLASS_LO    4
`define LOS_CLASS_FLT_D 2'h2
`define LOS_CLASS_FLT_S 2'h3
// write operand kinds
`define LOS_KIND_WORD   2'h0
`define LOS_KIND_DWORD  2'h1
`define LOS_KIND_HALF   2'h2
`define LOS_KIND_SHORT  2'h3
`endif

// file: core/los_reg_bank.v
/*
 * a bank of words with one write port and two registered read ports.
 * assumes the caller keeps write index in range.
 */
`timescale 1ns/1ps
module los_reg_bank #(
	parameter WIDTH = 32,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	// clock and reset
	input  wire             ref_clk,
	input  wire             srst,
	// write port
	input  wire             wr_en,
	input  wire [AW-1:0]    wr_idx,
	input  wire [WIDTH-1:0] wr_data,
	// read ports
	input  wire [AW-1:0]    rd_a_idx,
	input  wire [AW-1:0]    rd_b_idx,
	output reg  [WIDTH-1:0] rd_a_reg,
	output reg  [WIDTH-1:0] rd_b_reg
);
	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
	integer i;

	// read before write: a same-cycle read returns the old word
	always @(posedge ref_clk)
	begin
		if (srst)
		begin
			for (i = 0; i < DEPTH; i = i + 1)
				mem_reg[i] <= {WIDTH{1'b0}};
			rd_a_reg <= {WIDTH{1'b0}};
			rd_b_reg <= {WIDTH{1'b0}};
		end
		else
		begin
			rd_a_reg <= mem_reg[rd_a_idx]; // RQ19
			rd_b_reg <= mem_reg[rd_b_idx];
			if (wr_en)
				mem_reg[wr_idx] <= wr_data; // RQ19
		end
	end
endmodule // los_reg_bank

// file: core/los_sign_ext.v
/*
 * combinational sign extension of a narrow fixed-point value.
 * assumes IN_W is not above OUT_W.
 */
`timescale 1ns/1ps
module los_sign_ext #(
	parameter IN_W  = 16,
	parameter OUT_W = 32
) (
	// narrow value, sign in its msb
	input  wire [IN_W-1:0]  din,
	// widened value
	output wire [OUT_W-1:0] dout
);
	// every added high bit copies the sign
	assign dout = {{(OUT_W-IN_W){din[IN_W-1]}}, din}; // RQ11
endmodule // los_sign_ext

// file: core/los_store.v
/*
 * local operand store: sixteen general registers, four floating
 * registers, operand formatting for halfword, doubleword and short
 * floating forms, immediate byte extraction and zero base/index.
 * assumes the execution datapath holds its request stable only for the
 * cycle it is presented; results come two cycles later from flip-flops.
 * write faults pulse one cycle after the write, read faults two.
 * storage alignment is the fetch path's job and is not checked here.
 */
`timescale 1ns/1ps
`include "los_defs.vh"
module los_store #(
	parameter WW = `LOS_WORD_W,
	parameter DW = `LOS_DWORD_W,
	parameter SW = `LOS_SEL_W
) (
	// clock and reset
	input  wire          ref_clk,
	input  wire          srst,
	// instruction fields
	input  wire [`LOS_OP_W-1:0]   op_code,
	input  wire [`LOS_INSN_W-1:0] insn_half,
	// read request
	input  wire          rd_req,
	input  wire          rd_dword,
	input  wire          rd_addr_comp,
	input  wire [SW-1:0] first_register_select,
	input  wire [SW-1:0] second_register_select,
	// write request
	input  wire          wr_req,
	input  wire [1:0]    wr_kind,
	input  wire [SW-1:0] wr_select,
	input  wire [DW-1:0] wr_data,
	// results
	output reg  [DW-1:0] rd_data_reg,
	output reg  [WW-1:0] rd_second_reg,
	output reg           rd_valid_reg,
	output reg  [WW-1:0] immediate_second_operand_reg,
	output reg           spec_fault_reg,
	output reg           flt_sign_reg,
	output reg  [`LOS_CHAR_W-1:0] flt_char_reg,
	output reg  [`LOS_DIGIT_W-1:0] dec_hi_digit_reg,
	output reg  [`LOS_DIGIT_W-1:0] dec_lo_digit_reg
);
	// class decode from op code only
	// the register field never picks the set; only the op code does
	wire [1:0] op_class = op_code[`LOS_CLASS_HI:`LOS_CLASS_LO];
	wire       use_flt  = (op_class == `LOS_CLASS_FLT_D) ||
	                      (op_class == `LOS_CLASS_FLT_S); // RQ4

	// floating select legal only for 0, 2, 4, 6
	// bit 0 marks an odd select, bit 3 one of eight or above
	wire rd_flt_bad = first_register_select[0] ||
	                  first_register_select[3]; // RQ3
	wire wr_flt_bad = wr_select[0] || wr_select[3]; // RQ3
	wire wr_gen_bad = (wr_kind == `LOS_KIND_DWORD) && wr_select[0];
	wire rd_gen_bad = rd_dword && first_register_select[0]; // RQ6

	// odd partner of a doubleword write; reads pair through the row
	// index, since both halves of a pair share one row of each bank
	wire [SW-1:0] wpair_odd = {wr_select[SW-1:1], 1'b1};

	// halfword from storage lands in bits 16-31 with sign copied above
	wire [WW-1:0] half_ext;
	los_sign_ext #(
		.IN_W  (`LOS_HALF_W),
		.OUT_W (WW)
	) u_half_ext (
		.din  (wr_data[`LOS_HALF_W-1:0]),
		.dout (half_ext)
	); // RQ15

	// general bank write steering
	// an odd doubleword write is dropped without a fault, while a
	// read of that form raises one
	// halfwords ride in the low sixteen bits of the write data
	reg           gen_we;
	reg [SW-1:0]  gen_widx;
	reg [WW-1:0]  gen_wdata;
	reg           gen_we2;
	reg [WW-1:0]  gen_wdata2;
	always @*
	begin
		gen_we     = 1'b0;
		gen_widx   = wr_select;
		gen_wdata  = wr_data[WW-1:0];
		gen_we2    = 1'b0;
		gen_wdata2 = wr_data[WW-1:0];
		if (wr_req && !use_flt)
		begin
			if (wr_kind == `LOS_KIND_DWORD)
			begin
				if (!wr_gen_bad)
				begin
					// even takes high half with sign, odd the low half
					gen_we     = 1'b1;
					gen_wdata  = wr_data[DW-1:WW]; // RQ12
					gen_we2    = 1'b1;
					gen_wdata2 = wr_data[WW-1:0]; // RQ13
				end
			end
			else if (wr_kind == `LOS_KIND_HALF)
			begin
				gen_we    = 1'b1;
				gen_wdata = half_ext; // RQ15
			end
			else
			begin
				gen_we    = 1'b1; // RQ5
				gen_wdata = wr_data[WW-1:0];
			end
		end
	end

	// two banks of words: even-index words and odd-index words
	// lets a doubleword write both halves in one cycle
	// trade-off: a mux on the odd write port instead of a second
	// write cycle for every doubleword
	wire           even_we = (gen_we && !gen_widx[0]);
	wire           odd_we  = (gen_we && gen_widx[0]) || gen_we2;
	wire [WW-1:0]  odd_wd  = gen_we2 ? gen_wdata2 : gen_wdata;
	wire [SW-2:0]  wrow    = gen_we2 ? wpair_odd[SW-1:1] :
	                         gen_widx[SW-1:1];
	wire [WW-1:0]  even_a;
	wire [WW-1:0]  even_b;
	wire [WW-1:0]  odd_a;
	wire [WW-1:0]  odd_b;
	wire [SW-2:0]  row_a   = first_register_select[SW-1:1];
	wire [SW-2:0]  row_b   = second_register_select[SW-1:1];

	// even registers 0,2,..,14
	los_reg_bank #(
		.WIDTH (WW),
		.DEPTH (`LOS_GEN_COUNT/2),
		.AW    (SW-1)
	) u_gen_even (
		.ref_clk  (ref_clk),
		.srst     (srst),
		.wr_en    (even_we),
		.wr_idx   (gen_widx[SW-1:1]),
		.wr_data  (gen_wdata),
		.rd_a_idx (row_a),
		.rd_b_idx (row_b),
		.rd_a_reg (even_a),
		.rd_b_reg (even_b)
	); // RQ2

	// odd registers 1,3,..,15
	los_reg_bank #(
		.WIDTH (WW),
		.DEPTH (`LOS_GEN_COUNT/2),
		.AW    (SW-1)
	) u_gen_odd (
		.ref_clk  (ref_clk),
		.srst     (srst),
		.wr_en    (odd_we),
		.wr_idx   (wrow),
		.wr_data  (odd_wd),
		.rd_a_idx (row_a),
		.rd_b_idx (row_b),
		.rd_a_reg (odd_a),
		.rd_b_reg (odd_b)
	); // RQ2

	// floating registers, 64 bits each
	// only four exist, so they stay plain flip-flops here; a bad
	// select writes none of them and its read returns zero data
	reg [DW-1:0] flt_reg [0:`LOS_FLT_COUNT-1];
	wire [1:0]   flt_widx = wr_select[2:1];
	wire [1:0]   flt_ridx = first_register_select[2:1];
	integer k;
	always @(posedge ref_clk)
	begin
		if (srst)
		begin
			for (k = 0; k < `LOS_FLT_COUNT; k = k + 1)
				flt_reg[k] <= {DW{1'b0}};
		end
		else if (wr_req && use_flt && !wr_flt_bad)
		begin
			// short write touches only the upper word
			if (wr_kind == `LOS_KIND_SHORT)
				flt_reg[flt_widx][DW-1:WW] <= wr_data[DW-1:WW]; // RQ8
			else
				flt_reg[flt_widx] <= wr_data; // RQ7
		end
	end

	// request pipeline so bank read data lines up with its request
	// the banks register their read data already, so the request
	// flags travel one stage to meet it
	reg          p_valid_reg;
	reg          p_flt_reg;
	reg          p_dword_reg;
	reg          p_short_reg;
	reg          p_zero_a_reg;
	reg          p_zero_b_reg;
	reg          p_odd_a_reg;
	reg          p_odd_b_reg;
	reg          p_bad_reg;
	reg [DW-1:0] p_flt_data_reg;
	always @(posedge ref_clk)
	begin
		if (srst)
		begin
			p_valid_reg    <= 1'b0;
			p_flt_reg      <= 1'b0;
			p_dword_reg    <= 1'b0;
			p_short_reg    <= 1'b0;
			p_zero_a_reg   <= 1'b0;
			p_zero_b_reg   <= 1'b0;
			p_odd_a_reg    <= 1'b0;
			p_odd_b_reg    <= 1'b0;
			p_bad_reg      <= 1'b0;
			p_flt_data_reg <= {DW{1'b0}};
		end
		else
		begin
			p_valid_reg  <= rd_req;
			p_flt_reg    <= use_flt;
			p_dword_reg  <= rd_dword;
			p_short_reg  <= (op_class == `LOS_CLASS_FLT_S);
			// zero field as base or index means value zero
			p_zero_a_reg <= rd_addr_comp &&
			                (first_register_select == 4'h0); // RQ18
			p_zero_b_reg <= rd_addr_comp &&
			                (second_register_select == 4'h0); // RQ18
			p_odd_a_reg  <= first_register_select[0];
			p_odd_b_reg  <= second_register_select[0];
			p_bad_reg    <= rd_req && (use_flt ? rd_flt_bad :
			                rd_gen_bad); // RQ3
			// old value on a same-cycle write
			p_flt_data_reg <= flt_reg[flt_ridx]; // RQ19
		end
	end

	// result assembly
	// priority: refused access, floating forms, pair, zero base and
	// then a plain word; a request that sets several of them gets the first
	reg [DW-1:0] res_next;
	reg [WW-1:0] sec_next;
	reg [WW-1:0] word_a;
	always @*
	begin
		word_a   = p_odd_a_reg ? odd_a : even_a;
		sec_next = p_zero_b_reg ? {WW{1'b0}} :
		           (p_odd_b_reg ? odd_b : even_b);
		if (p_bad_reg)
			res_next = {DW{1'b0}};
		else if (p_flt_reg && p_short_reg)
			res_next = {p_flt_data_reg[DW-1:WW], {WW{1'b0}}}; // RQ8
		else if (p_flt_reg)
			res_next = p_flt_data_reg; // RQ7
		else if (p_dword_reg)
			res_next = {even_a, odd_a}; // RQ6 RQ12 RQ13
		else if (p_zero_a_reg)
			res_next = {DW{1'b0}}; // RQ18
		else
			// a word read is widened with its own sign
			res_next = {{(DW-WW){word_a[WW-1]}}, word_a}; // RQ9 RQ10 RQ11
	end

	// floating fields of the word read out; fraction is the rest
	// sign and characteristic follow the floating read data every
	// cycle and mean something only alongside rd_valid_reg
	wire [DW-1:0] fsrc = p_flt_data_reg;

	// immediate byte and decimal digits come straight from the insn
	// limitation: they follow insn_half whether or not the
	// instruction in flight uses an immediate or decimal field
	always @(posedge ref_clk)
	begin
		if (srst)
		begin
			rd_data_reg   <= {DW{1'b0}};
			rd_second_reg <= {WW{1'b0}};
			rd_valid_reg  <= 1'b0;
			spec_fault_reg <= 1'b0;
			flt_sign_reg  <= 1'b0;
			flt_char_reg  <= {`LOS_CHAR_W{1'b0}};
			immediate_second_operand_reg <= {WW{1'b0}};
			dec_hi_digit_reg <= {`LOS_DIGIT_W{1'b0}};
			dec_lo_digit_reg <= {`LOS_DIGIT_W{1'b0}};
		end
		else
		begin
			rd_data_reg    <= res_next;
			rd_second_reg  <= sec_next;
			rd_valid_reg   <= p_valid_reg && !p_bad_reg;
			// fault replaces the access, one pulse per bad request
			spec_fault_reg <= p_bad_reg ||
			                  (wr_req && use_flt && wr_flt_bad); // RQ3
			flt_sign_reg   <= fsrc[DW-1]; // RQ16
			flt_char_reg   <= fsrc[DW-2:DW-1-`LOS_CHAR_W]; // RQ16
			// unsigned logical byte, zero filled above
			immediate_second_operand_reg <= {{(WW-8){1'b0}},
				insn_half[`LOS_IMM_HI:`LOS_IMM_LO]}; // RQ1
			dec_hi_digit_reg <= insn_half[7:4]; // RQ17
			dec_lo_digit_reg <= insn_half[3:0]; // RQ17
		end
	end
endmodule // los_store

// file: testbench/local_operand_store_and_formats_tb_top.sv
/*
 * self-checking bench for the local operand store.
 * assumes read results stand from the edge after the taking edge.
 */
`timescale 1ns/1ps
module local_operand_store_and_formats_tb_top;
	logic ref_clk = 0, srst = 1, rd_req = 0, rd_dword = 0;
	logic rd_addr_comp = 0, wr_req = 0, fetch_en = 0;
	logic [7:0] op_code = 8'h00;
	logic [15:0] insn_half = 16'h0000, half_data;
	logic [3:0] first_register_select = 0, second_register_select = 0;
	logic [3:0] wr_select = 0, dec_hi_digit_reg, dec_lo_digit_reg;
	logic [1:0] wr_kind = 0;
	logic [63:0] wr_data = 0, rd_data_reg;
	logic [31:0] rd_second_reg, immediate_second_operand_reg;
	logic rd_valid_reg, spec_fault_reg, flt_sign_reg;
	logic [6:0] flt_char_reg;
	logic [23:0] fetch_addr = 0;
	int error_cnt = 0, num_checks = 0;
	los_store dut_u (.*);
	los_fetch_model fm_u (.*);
	// 20 MHz clock
	always #25 ref_clk = ~ref_clk;
	task chk(input string what, input logic [63:0] exp, got);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", what, exp, got);
		end
	endtask
	// write pulse; req dropped on the taking edge
	task wr(input logic [7:0] op, input logic [1:0] k, input logic [3:0] s,
		input logic [63:0] d);
		@(posedge ref_clk);
		op_code <= op;
		wr_kind <= k;
		wr_select <= s;
		wr_data <= d;
		wr_req <= 1'b1;
		@(posedge ref_clk);
		wr_req <= 1'b0;
	endtask
	// read pulse; results stand from the edge after the taking edge
	task rd(input logic [7:0] op, input logic [3:0] s, s2, input logic dw, ac);
		@(posedge ref_clk);
		op_code <= op;
		first_register_select <= s;
		second_register_select <= s2;
		rd_dword <= dw;
		rd_addr_comp <= ac;
		rd_req <= 1'b1;
		@(posedge ref_clk);
		rd_req <= 1'b0;
		@(posedge ref_clk);
		#1;
	endtask
	task t_gen;
		logic [31:0] w;
		for (int i = 0; i < 16; i++)
			wr(8'h00, 2'h0, i[3:0], {32'hDEADBEEF, i[3:0], 28'h0123456});
		for (int i = 0; i < 16; i++)
		begin
			w = {i[3:0], 28'h0123456};
			rd(8'h00, i[3:0], 4'h0, 1'b0, 1'b0);
			chk("gen word", {{32{w[31]}}, w}, rd_data_reg);
			chk("gen valid", 64'h1, {63'h0, rd_valid_reg});
		end
		$display("done t_gen");
	endtask
	task t_dword;
		wr(8'h00, 2'h1, 4'h4, 64'h80000001F0000002);
		wr(8'h00, 2'h1, 4'h5, 64'h0);
		rd(8'h00, 4'h4, 4'h0, 1'b1, 1'b0);
		chk("pair", 64'h80000001F0000002, rd_data_reg);
		rd(8'h00, 4'h5, 4'h0, 1'b0, 1'b0);
		chk("odd word", 64'hFFFFFFFFF0000002, rd_data_reg);
		rd(8'h00, 4'h5, 4'h0, 1'b1, 1'b0);
		chk("odd pair fault", 64'h1, {63'h0, spec_fault_reg});
		$display("done t_dword");
	endtask
	task t_half;
		logic [15:0] h;
		for (int a = 0; a < 16; a += 8)
		begin
			@(posedge ref_clk);
			fetch_en <= 1'b1;
			fetch_addr <= a[23:0];
			#1;
			h = half_data;
			wr(8'h00, 2'h2, 4'h7, {48'h123456789ABC, h});
			fetch_en <= 1'b0;
			rd(8'h00, 4'h7, 4'h0, 1'b0, 1'b0);
			chk("half", {{48{h[15]}}, h}, rd_data_reg);
		end
		$display("done t_half");
	endtask
	task t_flt;
		logic [3:0] bad [4] = '{4'h1, 4'h3, 4'h8, 4'hF};
		wr(8'h20, 2'h1, 4'h2, 64'hC295400012345678);
		wr(8'h20, 2'h1, 4'h3, 64'h0);
		rd(8'h20, 4'h2, 4'h0, 1'b0, 1'b0);
		chk("long", 64'hC295400012345678, rd_data_reg);
		chk("sign char", 64'hC2, {flt_sign_reg, flt_char_reg});
		rd(8'h00, 4'h2, 4'h0, 1'b0, 1'b0);
		chk("gen not flt", 64'h20123456, rd_data_reg);
		wr(8'h20, 2'h1, 4'h4, 64'h0000000099999999);
		wr(8'h30, 2'h3, 4'h4, 64'h4110000055555555);
		rd(8'h30, 4'h4, 4'h0, 1'b0, 1'b0);
		chk("short", 64'h4110000000000000, rd_data_reg);
		rd(8'h20, 4'h4, 4'h0, 1'b0, 1'b0);
		chk("short lo", 64'h4110000099999999, rd_data_reg);
		for (int i = 0; i < 4; i++)
		begin
			rd(8'h20, bad[i], 4'h0, 1'b0, 1'b0);
			chk("bad flt", 64'h2, {spec_fault_reg, rd_valid_reg});
		end
		$display("done t_flt");
	endtask
	task t_imm;
		logic [15:0] v [2] = '{16'hA5FF, 16'h5A09};
		for (int i = 0; i < 2; i++)
		begin
			@(posedge ref_clk);
			insn_half <= v[i];
			@(posedge ref_clk);
			#1;
			chk("imm", v[i][7:0], immediate_second_operand_reg);
			chk("digits", v[i][7:0], {dec_hi_digit_reg, dec_lo_digit_reg});
		end
		$display("done t_imm");
	endtask
	task t_zero;
		rd(8'h00, 4'h0, 4'h0, 1'b0, 1'b1);
		chk("zero base", 64'h0, {rd_second_reg, rd_data_reg[31:0]});
		rd(8'h00, 4'h0, 4'h3, 1'b0, 1'b1);
		chk("index", 64'h30123456, rd_second_reg);
		rd(8'h00, 4'h0, 4'h0, 1'b0, 1'b0);
		chk("reg zero", 64'h00123456, rd_second_reg);
		$display("done t_zero");
	endtask
	task t_rw;
		wr(8'h00, 2'h0, 4'h9, 64'h11111111);
		@(posedge ref_clk);
		wr_data <= 64'h22222222;
		first_register_select <= 4'h9;
		rd_dword <= 1'b0;
		rd_addr_comp <= 1'b0;
		wr_req <= 1'b1;
		rd_req <= 1'b1;
		@(posedge ref_clk);
		wr_req <= 1'b0;
		rd_req <= 1'b0;
		@(posedge ref_clk);
		#1 chk("old value", 64'h11111111, rd_data_reg);
		rd(8'h00, 4'h9, 4'h0, 1'b0, 1'b0);
		chk("new value", 64'h22222222, rd_data_reg);
		$display("done t_rw");
	endtask
	task summarize;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// reset for eight cycles, then every scenario in turn
	initial
	begin
		repeat (8) @(posedge ref_clk);
		srst <= 1'b0;
		t_gen;
		t_dword;
		t_half;
		t_flt;
		t_imm;
		t_zero;
		t_rw;
		summarize;
	end
endmodule // local_operand_store_and_formats_tb_top

// file: testbench/los_fetch_model.sv
/*
 * main storage fetch model feeding halfwords to the store.
 * assumes the requester only asks for even byte addresses.
 */
`timescale 1ns/1ps
module los_fetch_model (
	// clock
	input wire logic		ref_clk,
	// fetch request
	input wire logic		fetch_en,
	input wire logic [23:0]		fetch_addr,
	// fetched halfword
	output logic [15:0]		half_data
);
	logic [15:0] last_reg;
	// content keyed on halfword index; address bit 0 is never used
	// because halfwords sit on even addresses
	wire [15:0] word_val = 16'h8001 ^ {fetch_addr[3:1], 13'h0000};
	// idle bus shows the inverse so a stale copy is never mistaken
	always @*
		half_data = fetch_en ? word_val : ~last_reg;
	always @(posedge ref_clk)
		if (fetch_en)
			last_reg <= word_val;
endmodule // los_fetch_model

// file: testbench/los_store_assertions.sv
/*
 * port-level checker for the local operand store.
 * assumes one clock and synchronous active-high reset.
 */
`timescale 1ns/1ps
module los_store_chk #(
	parameter WW = 32,
	parameter DW = 64,
	parameter SW = 4
) (
	// clock and reset
	input wire logic		ref_clk,
	input wire logic		srst,
	// requests
	input wire logic [7:0]		op_code,
	input wire logic [15:0]		insn_half,
	input wire logic		rd_req,
	input wire logic		rd_dword,
	input wire logic		rd_addr_comp,
	input wire logic [SW-1:0]	first_register_select,
	input wire logic [SW-1:0]	second_register_select,
	input wire logic		wr_req,
	input wire logic [1:0]		wr_kind,
	input wire logic [SW-1:0]	wr_select,
	input wire logic [DW-1:0]	wr_data,
	// results
	input wire logic [DW-1:0]	rd_data_reg,
	input wire logic [WW-1:0]	rd_second_reg,
	input wire logic		rd_valid_reg,
	input wire logic [WW-1:0]	immediate_second_operand_reg,
	input wire logic		spec_fault_reg,
	input wire logic		flt_sign_reg,
	input wire logic [6:0]		flt_char_reg,
	input wire logic [3:0]		dec_hi_digit_reg,
	input wire logic [3:0]		dec_lo_digit_reg
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	// floating class and the addresses that have no floating register
	wire flt_op = op_code[5];
	wire bad_rd = first_register_select[0] | first_register_select[3];
	wire bad_wr = wr_select[0] | wr_select[3];
	sequence s_good;
		##2 rd_valid_reg && !spec_fault_reg;
	endsequence
	sequence s_bad;
		##2 spec_fault_reg && !rd_valid_reg;
	endsequence
	a_valid_has_req: assert property (rd_valid_reg |-> $past(rd_req, 2))
		else $error("valid without request");
	a_flt_bad_sel: assert property (rd_req && flt_op && bad_rd |-> s_bad)
		else $error("bad float read not refused");
	a_flt_good_sel: assert property (rd_req && flt_op && !bad_rd |-> s_good)
		else $error("good float read refused");
	a_dword_odd_sel: assert property (rd_req && !flt_op && rd_dword &&
		first_register_select[0] |-> s_bad) else $error("odd pair read");
	a_short_low_zero: assert property (rd_req && op_code[5:4] == 2'h3 &&
		!bad_rd |-> ##2 rd_data_reg[31:0] == 32'h0) else $error("short low");
	a_zero_index: assert property (rd_req && rd_addr_comp &&
		second_register_select == 0 |-> ##2 rd_second_reg == 0)
		else $error("zero index not zero");
	a_imm_byte: assert property (1'b1 |=> immediate_second_operand_reg ==
		{{(WW-8){1'b0}}, $past(insn_half[7:0])}) else $error("imm byte");
	a_wr_fault: assert property (wr_req && flt_op && bad_wr |=> spec_fault_reg)
		else $error("bad float write no fault");
endmodule // los_store_chk

bind los_store los_store_chk #(.WW(WW), .DW(DW), .SW(SW)) chk_u (.*);
